// ===== logic/frame_packer_pkg.sv
// Constants and types shared by the current report frame packer.
//
// Summary of operation
// - Coarse current value is clamped to -1550 A and +1550 A.
// - Coarse current is 16-bit offset binary, 1 A steps, zero 0x8000, bytes 4 and 5.
// - Byte 7 holds an 8-bit SAE J1850 CRC over bytes 0 to 6.
// - Frame goes out with identifier 0x3C2 once every 10 ms.
// - Byte 0 holds sequence count, supply status, internal fault flag and plausibility flag.
// - Sequence count starts at 0, steps by one, wraps from 15 to 1.
// - Supply status reads binary 11 while no supply measurement is available.
// - No frame at start-up while supply is below 7.8 V or above 16.2 V.
// - Internal fault flag follows detected internal hardware errors.
// - Fine current is 24-bit offset binary, 1 mA steps, zero 0x800000, MSB first.
// - Fine current equals the measured current across -1550 A to +1550 A.
// - Plausibility flag sets on over 20 % mismatch between 220 A and 1500 A.
// - Plausibility flag sets on over 44 A mismatch within plus or minus 220 A.
// - With coarse variant, currents above 1600 A also raise the internal fault flag.
package frame_packer_pkg;

  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam int          REF_CLK_HZ          = 25000000;
  localparam int          FRAME_PERIOD_MS     = 10;
  localparam int          FRAME_PERIOD_CYCLES = REF_CLK_HZ / 1000 * FRAME_PERIOD_MS;

  // ---------------------------------------------------------------------------
  // Frame identity and field layout
  // ---------------------------------------------------------------------------
  localparam logic [10:0] FRAME_ID            = 11'h3C2;
  localparam int          SEQ_POS             = 4;
  localparam int          SUPPLY_POS          = 2;
  localparam int          FAULT_POS           = 1;
  localparam int          PLAUS_POS           = 0;
  localparam logic [3:0]  SEQ_RESET           = 4'h0;
  localparam logic [3:0]  SEQ_LAST            = 4'hF;
  localparam logic [3:0]  SEQ_RESTART         = 4'h1;
  localparam logic [1:0]  SUPPLY_UNAVAILABLE  = 2'h3;

  // ---------------------------------------------------------------------------
  // Current coding
  // ---------------------------------------------------------------------------
  localparam logic [23:0] FINE_ZERO           = 24'h80_0000;
  localparam logic [15:0] COARSE_ZERO         = 16'h8000;
  localparam logic signed [31:0] FINE_LIMIT_MA   = 32'sh0017_A6B0;
  localparam logic signed [15:0] COARSE_LIMIT_A  = 16'sh060E;
  localparam logic signed [31:0] MA_PER_A        = 32'sh0000_03E8;
  localparam logic signed [31:0] OVERCURRENT_MA  = 32'sh0018_6A00;
  localparam logic signed [31:0] BAND_LOW_MA     = 32'sh0003_5B60;
  localparam logic signed [31:0] BAND_HIGH_MA    = 32'sh0016_E360;
  localparam logic signed [31:0] GAP_MA          = 32'sh0000_ABE0;
  localparam logic signed [31:0] RATIO_DIV       = 32'sh0000_0005;

  // ---------------------------------------------------------------------------
  // Supply window in millivolts
  // ---------------------------------------------------------------------------
  localparam logic [15:0] SUPPLY_MIN_MV       = 16'h1E78;
  localparam logic [15:0] SUPPLY_MAX_MV       = 16'h3F48;

  // ---------------------------------------------------------------------------
  // Check byte
  // ---------------------------------------------------------------------------
  localparam logic [7:0]  CRC_POLY            = 8'h1D;
  localparam logic [7:0]  CRC_INIT            = 8'hFF;
  localparam logic [7:0]  CRC_XOROUT          = 8'hFF;

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {
    WAIT_SUPPLY = 2'b00,
    IDLE        = 2'b01,
    SEAL        = 2'b10,
    OFFER       = 2'b11
  } phase_e;

  typedef struct packed {
    phase_e       phase;
    logic [17:0]  timer;
    logic [3:0]   seq;
    logic [55:0]  payload;
    logic [63:0]  data;
    logic         valid;
    logic [10:0]  frame_id;
  } packer_s;

endpackage : frame_packer_pkg

// ===== logic/frame_check_byte.sv
// Combinational SAE J1850 check byte over seven frame bytes.
module frame_check_byte (
  // Bytes 0 to 6, byte 0 in the top eight bits
  input  wire logic [55:0] bytes_in,
  // Finished check byte
  output logic      [7:0]  check_out
);
  import frame_packer_pkg::*;

  logic [7:0] chain [0:56];

  assign chain[0] = CRC_INIT;

  // ---------------------------------------------------------------------------
  // Bitwise shift register, most significant bit of byte 0 first.
  // ---------------------------------------------------------------------------
  for (genvar i = 0; i < 56; i++) begin : g_bit
    assign chain[i + 1] = {chain[i][6:0], 1'b0}
                        ^ ((chain[i][7] ^ bytes_in[55 - i]) ? CRC_POLY : 8'h00);
  end

  assign check_out = chain[56] ^ CRC_XOROUT;

endmodule : frame_check_byte

// ===== logic/current_report_frame_packer.sv
// Periodic current report frame builder for the CAN controller.
module current_report_frame_packer #(
  parameter int PERIOD_CYCLES = frame_packer_pkg::FRAME_PERIOD_CYCLES
) (
  // Clock and reset
  input  wire logic                ref_clk_in,
  input  wire logic                reset_n_in,
  // Measurements
  input  wire logic signed [31:0]  fine_current_ma_in,
  input  wire logic signed [15:0]  coarse_current_a_in,
  input  wire logic                supply_measure_valid_in,
  input  wire logic [15:0]         supply_mv_in,
  input  wire logic [1:0]          supply_status_field_in,
  input  wire logic                hw_fault_in,
  // Configuration
  input  wire logic                coarse_variant_in,
  // Frame hand-off to the CAN controller
  input  wire logic                frame_ready_in,
  output logic                     frame_valid_out,
  output logic [10:0]              frame_id_out,
  output logic [63:0]              current_report_message_out,
  output logic [3:0]               frame_sequence_counter_out
);
  import frame_packer_pkg::*;

  localparam logic [17:0] TIMER_LAST = 18'(PERIOD_CYCLES - 1);

  packer_s s;
  packer_s next_s;

  // ---------------------------------------------------------------------------
  // Fine current saturation and coding
  // ---------------------------------------------------------------------------
  logic signed [31:0] fine_sat;
  logic signed [31:0] fine_abs_raw;
  logic signed [31:0] fine_abs;
  logic [23:0]        fine_code;

  always_comb begin
    if (fine_current_ma_in > FINE_LIMIT_MA) begin
      fine_sat = FINE_LIMIT_MA;
    end else if (fine_current_ma_in < -FINE_LIMIT_MA) begin
      fine_sat = -FINE_LIMIT_MA;
    end else begin
      fine_sat = fine_current_ma_in;
    end
    fine_abs_raw = (fine_current_ma_in < 0) ? -fine_current_ma_in : fine_current_ma_in;
    fine_abs     = (fine_sat < 0) ? -fine_sat : fine_sat;
    fine_code    = 24'(fine_sat[23:0] + FINE_ZERO);
  end

  // ---------------------------------------------------------------------------
  // Coarse current clamp and coding
  // ---------------------------------------------------------------------------
  logic signed [15:0] coarse_clamp;
  logic [15:0]        coarse_code;

  always_comb begin
    if (coarse_current_a_in > COARSE_LIMIT_A) begin
      coarse_clamp = COARSE_LIMIT_A;
    end else if (coarse_current_a_in < -COARSE_LIMIT_A) begin
      coarse_clamp = -COARSE_LIMIT_A;
    end else begin
      coarse_clamp = coarse_current_a_in;
    end
    coarse_code = 16'(coarse_clamp + COARSE_ZERO);
  end

  // ---------------------------------------------------------------------------
  // Plausibility between fine and coarse paths
  // ---------------------------------------------------------------------------
  // The fine path is the reference for both band choice and the 20 % ratio,
  // since it is the more accurate of the two measurements.
  logic signed [31:0] coarse_ma;
  logic signed [31:0] diff_ma;
  logic signed [31:0] diff_abs;
  logic               plaus_fail;

  always_comb begin
    coarse_ma  = 32'(coarse_clamp) * MA_PER_A;
    diff_ma    = fine_sat - coarse_ma;
    diff_abs   = (diff_ma < 0) ? -diff_ma : diff_ma;
    plaus_fail = 1'b0;
    if (fine_abs <= BAND_LOW_MA) begin
      plaus_fail = diff_abs > GAP_MA;
    end else if (fine_abs <= BAND_HIGH_MA) begin
      plaus_fail = (diff_abs * RATIO_DIV) > fine_abs;
    end
  end

  // ---------------------------------------------------------------------------
  // Status and payload assembly
  // ---------------------------------------------------------------------------
  logic [1:0]  supply_status_field;
  logic        internal_fault;
  logic        plaus_bit;
  logic [7:0]  byte0;
  logic [15:0] coarse_bytes;
  logic [55:0] payload_now;
  logic        supply_ok;

  always_comb begin
    supply_status_field = supply_measure_valid_in ? supply_status_field_in
                                                  : SUPPLY_UNAVAILABLE;
    internal_fault = hw_fault_in
                   | (coarse_variant_in & (fine_abs_raw > OVERCURRENT_MA));
    plaus_bit    = coarse_variant_in & plaus_fail;
    coarse_bytes = coarse_variant_in ? coarse_code : 16'h0000;
    byte0        = 8'h00;
    byte0[SEQ_POS +: 4]    = s.seq;
    byte0[SUPPLY_POS +: 2] = supply_status_field;
    byte0[FAULT_POS]       = internal_fault;
    byte0[PLAUS_POS]       = plaus_bit;
    payload_now = {byte0, fine_code, coarse_bytes, 8'h00};
    // A missing measurement does not hold back start-up; only a reported
    // out-of-window voltage does.
    supply_ok = !supply_measure_valid_in
              || ((supply_mv_in >= SUPPLY_MIN_MV) && (supply_mv_in <= SUPPLY_MAX_MV));
  end

  // ---------------------------------------------------------------------------
  // Check byte
  // ---------------------------------------------------------------------------
  logic [7:0] check_byte;

  frame_check_byte u_check (
    .bytes_in  (s.payload),
    .check_out (check_byte)
  );

  // ---------------------------------------------------------------------------
  // Sequencing
  // ---------------------------------------------------------------------------
  logic tick;

  always_comb begin
    next_s = s;
    tick   = (s.timer == TIMER_LAST);
    next_s.timer = tick ? 18'h0_0000 : 18'(s.timer + 18'h0_0001);
    unique case (s.phase)
      WAIT_SUPPLY: begin
        next_s.timer = 18'h0_0000;
        if (supply_ok) begin
          next_s.payload = payload_now;
          next_s.phase   = SEAL;
        end
      end
      IDLE: begin
        if (tick) begin
          next_s.payload = payload_now;
          next_s.phase   = SEAL;
        end
      end
      SEAL: begin
        next_s.data  = {s.payload, check_byte};
        next_s.valid = 1'b1;
        next_s.phase = OFFER;
      end
      OFFER: begin
        // A frame still waiting when the next period ends simply absorbs that
        // period; bursts of stale frames would only confuse the receiver.
        if (frame_ready_in) begin
          next_s.valid = 1'b0;
          next_s.seq   = (s.seq == SEQ_LAST) ? SEQ_RESTART : 4'(s.seq + 4'h1);
          next_s.phase = IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      s.phase    <= WAIT_SUPPLY;
      s.timer    <= 18'h0_0000;
      s.seq      <= SEQ_RESET;
      s.payload  <= 56'h00_0000_0000_0000;
      s.data     <= 64'h0000_0000_0000_0000;
      s.valid    <= 1'b0;
      s.frame_id <= FRAME_ID;
    end else begin
      s <= next_s;
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------
  assign frame_valid_out            = s.valid;
  assign frame_id_out               = s.frame_id;
  assign current_report_message_out = s.data;
  assign frame_sequence_counter_out = s.seq;

endmodule : current_report_frame_packer

// ===== verif/frame_packer_monitor.sv
// Concurrent checks on the frame packer ports.
module frame_packer_monitor #(
  parameter int PERIOD_CYCLES = 64
) (
  // Clock, reset and inputs
  input wire logic               ref_clk_in,
  input wire logic               reset_n_in,
  input wire logic signed [31:0] fine_current_ma_in,
  input wire logic               supply_measure_valid_in,
  input wire logic               hw_fault_in,
  input wire logic               coarse_variant_in,
  input wire logic               frame_ready_in,
  // Frame offer
  input wire logic               frame_valid_out,
  input wire logic [10:0]        frame_id_out,
  input wire logic [63:0]        current_report_message_out,
  input wire logic [3:0]         frame_sequence_counter_out
);
  // Cycles since the last new offer; zero until the first one.
  int         gap;
  logic       was_valid;
  wire        rise = frame_valid_out && !was_valid;
  wire [63:0] msg  = current_report_message_out;
  wire [3:0]  seq  = frame_sequence_counter_out;
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      gap       <= 0;
      was_valid <= 1'b0;
    end else begin
      gap       <= rise ? 1 : (gap == 0 ? 0 : gap + 1);
      was_valid <= frame_valid_out;
    end
  end
  default clocking @(posedge ref_clk_in);
  endclocking
  default disable iff (!reset_n_in);
  a_id_fixed: assert property (frame_id_out == 11'h3C2) else $error("bad id");
  a_period_gap: assert property (rise |-> gap == 0 || gap >= PERIOD_CYCLES)
    else $error("frame too early");
  a_offer_hold: assert property (frame_valid_out && !frame_ready_in |=>
    frame_valid_out && $stable(msg)) else $error("offer dropped");
  a_seq_step: assert property (frame_valid_out && frame_ready_in |=>
    seq == (($past(seq) == 4'hF) ? 4'h1 : $past(seq) + 4'h1)) else $error("bad count");
  a_seq_byte0: assert property (frame_valid_out |-> msg[63:60] == seq) else $error("byte0");
  a_byte6_zero: assert property (frame_valid_out |-> msg[15:8] == 8'h00) else $error("b6");
  a_plain_zero: assert property (frame_valid_out && !coarse_variant_in |->
    msg[56] == 1'b0 && msg[31:16] == 16'h0000) else $error("reserved set");
  a_fault_bit: assert property (rise && $past(hw_fault_in, 2) |-> msg[57]) else $error("fault");
  a_no_supply: assert property (rise && !$past(supply_measure_valid_in, 2) |->
    msg[59:58] == 2'h3) else $error("supply status");
  a_fine_code: assert property (rise && $past(fine_current_ma_in, 2) <= 32'sh0017_A6B0 &&
    $past(fine_current_ma_in, 2) >= -32'sh0017_A6B0 |->
    msg[55:32] == $past(fine_current_ma_in[23:0], 2) + 24'h80_0000) else $error("fine");
  c_plaus: cover property (rise && msg[56]);
  c_wrap: cover property (frame_valid_out && frame_ready_in && seq == 4'hF);
  c_stall: cover property ((frame_valid_out && !frame_ready_in) [*8]);
endmodule : frame_packer_monitor
bind current_report_frame_packer frame_packer_monitor #(.PERIOD_CYCLES(PERIOD_CYCLES))
  i_frame_packer_monitor (
    .ref_clk_in                 (ref_clk_in),
    .reset_n_in                 (reset_n_in),
    .fine_current_ma_in         (fine_current_ma_in),
    .supply_measure_valid_in    (supply_measure_valid_in),
    .hw_fault_in                (hw_fault_in),
    .coarse_variant_in          (coarse_variant_in),
    .frame_ready_in             (frame_ready_in),
    .frame_valid_out            (frame_valid_out),
    .frame_id_out               (frame_id_out),
    .current_report_message_out (current_report_message_out),
    .frame_sequence_counter_out (frame_sequence_counter_out)
  );

// ===== verif/frame_sink_model.sv
// Behavioural CAN controller that takes frames and recomputes the check byte.
module frame_sink_model (
  // Clock and reset
  input  wire logic        ref_clk_in,
  input  wire logic        reset_n_in,
  // Frame hand-off
  input  wire logic        stall_in,
  input  wire logic        frame_valid_in,
  input  wire logic [63:0] frame_in,
  output logic             frame_ready_out,
  output logic             check_ok_out
);
  function automatic logic [7:0] crc_of(input logic [55:0] b);
    logic [7:0] c;
    c = 8'hFF;
    for (int i = 55; i >= 0; i--) begin
      c = (c[7] ^ b[i]) ? ({c[6:0], 1'b0} ^ 8'h1D) : {c[6:0], 1'b0};
    end
    return ~c;
  endfunction : crc_of
  // Ready is registered, so every offer is held at least one extra cycle.
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      frame_ready_out <= 1'b0;
      check_ok_out    <= 1'b0;
    end else begin
      frame_ready_out <= frame_valid_in && !frame_ready_out && !stall_in;
      if (frame_valid_in && frame_ready_out) begin
        check_ok_out <= crc_of(frame_in[63:8]) == frame_in[7:0];
      end
    end
  end
endmodule : frame_sink_model

// ===== verif/test_current_report_frame_packer.sv
// Self-checking bench for the current report frame packer.
module test_current_report_frame_packer;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {
    logic v; logic signed [31:0] f; logic signed [15:0] c; logic hw, sv; logic [1:0] st;
    logic [3:0] fl; logic [23:0] ef; logic [15:0] ec;
  } row_s;
  logic               ref_clk_in = 1'b0;
  logic               reset_n_in = 1'b0;
  logic signed [31:0] fine_current_ma_in = '0;
  logic signed [15:0] coarse_current_a_in = '0;
  logic               supply_measure_valid_in = 1'b1;
  logic [15:0]        supply_mv_in = 16'h1B58;
  logic [1:0]         supply_status_field_in = 2'h0;
  logic               hw_fault_in = 1'b0;
  logic               coarse_variant_in = 1'b1;
  logic               stall = 1'b0;
  logic               frame_ready_in, frame_valid_out, check_ok;
  logic [10:0]        frame_id_out;
  logic [63:0]        current_report_message_out;
  logic [3:0]         frame_sequence_counter_out;
  logic [3:0]         exp_seq = 4'h0;
  int                 err_count = 0, total_checks = 0, cycles = 0, seen = 0;
  row_s rows [8] = '{
    '{1'b1, 32'sh0000_0000, 16'sh0000, 1'b0, 1'b1, 2'h1, 4'h4, 24'h80_0000, 16'h8000},
    '{1'b1, 32'sh0017_A6B0, 16'sh0640, 1'b0, 1'b1, 2'h0, 4'h0, 24'h97_A6B0, 16'h860E},
    '{1'b1, -32'sh0016_E360, -16'sh05DC, 1'b1, 1'b0, 2'h0, 4'hE, 24'h69_1CA0, 16'h7A24},
    '{1'b1, 32'sh0001_86A0, 16'sh0032, 1'b0, 1'b1, 2'h2, 4'h9, 24'h81_86A0, 16'h8032},
    '{1'b1, 32'sh000F_4240, 16'sh02BC, 1'b0, 1'b1, 2'h1, 4'h5, 24'h8F_4240, 16'h82BC},
    '{1'b1, 32'sh0019_F0A0, 16'sh06A4, 1'b0, 1'b1, 2'h0, 4'h2, 24'h97_A6B0, 16'h860E},
    '{1'b0, 32'sh000F_4240, 16'sh02BC, 1'b0, 1'b1, 2'h1, 4'h4, 24'h8F_4240, 16'h0000},
    '{1'b1, -32'sh0000_0001, -16'sh06A4, 1'b0, 1'b1, 2'h0, 4'h1, 24'h7F_FFFF, 16'h79F2}};
  current_report_frame_packer #(.PERIOD_CYCLES(64)) i_current_report_frame_packer (
    .ref_clk_in                 (ref_clk_in),
    .reset_n_in                 (reset_n_in),
    .fine_current_ma_in         (fine_current_ma_in),
    .coarse_current_a_in        (coarse_current_a_in),
    .supply_measure_valid_in    (supply_measure_valid_in),
    .supply_mv_in               (supply_mv_in),
    .supply_status_field_in     (supply_status_field_in),
    .hw_fault_in                (hw_fault_in),
    .coarse_variant_in          (coarse_variant_in),
    .frame_ready_in             (frame_ready_in),
    .frame_valid_out            (frame_valid_out),
    .frame_id_out               (frame_id_out),
    .current_report_message_out (current_report_message_out),
    .frame_sequence_counter_out (frame_sequence_counter_out)
  );
  frame_sink_model i_frame_sink_model (.ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in),
    .stall_in(stall), .frame_valid_in(frame_valid_out), .frame_in(current_report_message_out),
    .frame_ready_out(frame_ready_in), .check_ok_out(check_ok));
  always #20 ref_clk_in = ~ref_clk_in;
  task automatic compare(input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, got, exp);
    end
  endtask : compare
  task automatic close_out();
    if (err_count == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : close_out
  // A hung handshake ends here rather than running forever.
  always @(posedge ref_clk_in) begin
    cycles++;
    if (frame_valid_out === 1'b1) seen++;
    if (cycles == 4000) begin
      err_count++;
      close_out();
    end
  end
  task automatic wait_frame();
    for (int n = 0; n < 200 && frame_valid_out !== 1'b1; n++) @(posedge ref_clk_in) #2;
    compare(frame_valid_out, 1'b1);
  endtask : wait_frame
  task automatic finish_frame();
    while (frame_valid_out === 1'b1) @(posedge ref_clk_in) #2;
    compare(check_ok, 1'b1);
    exp_seq = (exp_seq == 4'hF) ? 4'h1 : exp_seq + 4'h1;
    compare(frame_sequence_counter_out, exp_seq);
  endtask : finish_frame
  initial begin
    int t0;
    repeat (20) @(posedge ref_clk_in);
    #2 reset_n_in = 1'b1;
    repeat (100) @(posedge ref_clk_in) #2;
    supply_mv_in = 16'h4268;
    repeat (100) @(posedge ref_clk_in) #2;
    compare(seen, 0);
    compare(frame_id_out, 11'h3C2);
    foreach (rows[i]) begin
      {coarse_variant_in, fine_current_ma_in, coarse_current_a_in} = {rows[i].v, rows[i].f, rows[i].c};
      {hw_fault_in, supply_measure_valid_in} = {rows[i].hw, rows[i].sv};
      supply_status_field_in = rows[i].st;
      supply_mv_in = 16'h2EE0;
      wait_frame();
      compare(current_report_message_out[63:8], {exp_seq, rows[i].fl, rows[i].ef, rows[i].ec, 8'h00});
      finish_frame();
    end
    // Nine frames walk the count through 15 and back to 1.
    for (int k = 0; k < 9; k++) begin
      wait_frame();
      if (k > 0) compare(cycles - t0, 64);
      t0 = cycles;
      finish_frame();
    end
    stall = 1'b1;
    wait_frame();
    repeat (100) @(posedge ref_clk_in) #2;
    compare(frame_valid_out, 1'b1);
    stall = 1'b0;
    finish_frame();
    reset_n_in = 1'b0;
    repeat (2) @(posedge ref_clk_in) #2;
    compare({frame_valid_out, frame_sequence_counter_out, frame_id_out}, 16'h03C2);
    // After a mid-run reset the count must start again from zero.
    exp_seq = 4'h0;
    reset_n_in = 1'b1;
    wait_frame();
    compare(current_report_message_out[63:60], exp_seq);
    finish_frame();
    close_out();
  end
endmodule : test_current_report_frame_packer
